// ==== shared/eep_consts.svh ====
// register offsets, field positions, reset values and timing counts of the eeprom control block
`ifndef EEP_CONSTS_SVH
`define EEP_CONSTS_SVH

// ==================================================
// register byte addresses
`define EEP_ADDR_CONFIG 16'h0000
`define EEP_ADDR_PROTECT 16'h0004
`define EEP_ADDR_DIV_HIGH 16'h0008
`define EEP_ADDR_DIV_LOW 16'h000C
`define EEP_ADDR_CONTROL 16'h0010
`define EEP_ADDR_ARRAY_BASE 16'h4000
`define EEP_ARRAY_SEL_BITS 2'h1

// ==================================================
// shadow word slots within the array window
`define EEP_SHADOW_HIGH_OFS 12'hFC0
`define EEP_SHADOW_LOW_OFS 12'hFC1

// ==================================================
// field positions
`define EEP_CFG_DEBUG_LOCKOUT_DISABLE 7
`define EEP_CFG_SHADOW_HIDE 6
`define EEP_CFG_PROTECT_LOCK 1
`define EEP_PROT_SHADOW_WRITE_PROTECT 7
`define EEP_CTL_BULK_PROTECT 7
`define EEP_CTL_AUTO 5
`define EEP_CTL_BYTE 4
`define EEP_CTL_ROW 3
`define EEP_CTL_ERASE 2
`define EEP_CTL_LATCH_ENABLE 1
`define EEP_CTL_PROGRAM_VOLTAGE_ENABLE 0

// ==================================================
// reset values
`define EEP_CFG_LOW_RESET 4'hC
`define EEP_PROT_RESET 8'hFF
`define EEP_CTL_RESET 8'h80

// ==================================================
// timing: program and erase time against the self-timed pulse period
`define EEP_PROGRAM_TIME_US 10000
`define EEP_TICK_US 35
`define EEP_PROGRAM_TICKS ((`EEP_PROGRAM_TIME_US + `EEP_TICK_US - 1) / `EEP_TICK_US)

// ==================================================
// bus answers
`define EEP_RESP_OKAY 2'h0
`define EEP_RESP_SLVERR 2'h2

`endif

// ==== shared/eep_pkg.sv ====
// types shared by the eeprom control block
package eep_pkg;

    // ==================================================
    // kind of cycle presented to the array
    typedef enum logic [1:0] {
        EEP_OP_PROGRAM,
        EEP_OP_ERASE_WORD,
        EEP_OP_ERASE_ROW,
        EEP_OP_ERASE_BULK
    } eep_op_t;

endpackage

// ==== core/eep_tick_gen.sv ====
// self-timed pulse generator dividing the bus clock by the prescale divider
`timescale 1ns/1ps

module eep_tick_gen (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic run,
    input wire logic [9:0] divider,
    // pulse out
    output logic tick
);

    logic [9:0] count_reg;

    // ==================================================
    // divider counter, restarted whenever the cycle is not running
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            count_reg <= 10'h000;
        end else if (count_reg + 10'h001 >= divider) begin
            count_reg <= 10'h000;
        end else begin
            count_reg <= count_reg + 10'h001;
        end
    end

    assign tick = run && (divider != 10'h000) && (count_reg + 10'h001 >= divider);

endmodule

// ==== core/eep_program_erase_ctrl.sv ====
// eeprom program and erase controller with axi4-lite register access
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "eep_consts.svh"

module eep_program_erase_ctrl (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // mode and nonvolatile shadow contents
    input wire logic special_mode_n,
    input wire logic [7:0] shadow_high_in,
    input wire logic [7:0] shadow_low_in,
    // array read port
    output logic [11:0] array_raddr,
    input wire logic [7:0] array_rdata,
    // array program port
    output logic latch_enable,
    output logic program_voltage_enable,
    output logic [11:0] prog_addr,
    output logic [15:0] prog_data,
    output logic prog_word,
    output logic prog_shadow,
    output logic [1:0] prog_op,
    output logic debug_lockout_disable
);

    // ==================================================
    // state
    logic [7:0] cfg_reg;
    logic [7:0] prot_reg;
    logic [7:0] ctl_reg;
    logic [1:0] div_high_reg;
    logic [7:0] div_low_reg;
    logic div_high_locked_reg;
    logic div_low_locked_reg;
    logic load_pending_reg;
    logic [15:0] aw_addr_reg;
    logic aw_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_held_reg;
    logic [15:0] ar_addr_reg;
    logic rd_pending_reg;
    logic [8:0] tick_count_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic rvalid_reg;
    logic [1:0] bresp_reg;
    logic bvalid_reg;
    logic [11:0] latch_addr_reg;
    logic [15:0] latch_data_reg;
    logic latch_word_reg;

    logic do_write;
    logic tick;
    logic cycle_done;
    logic [9:0] divider;
    logic wr_array;
    logic [11:0] wr_ofs;
    logic shadow_mapped;
    logic pgm;

    assign divider = {div_high_reg, div_low_reg};
    assign pgm = ctl_reg[`EEP_CTL_PROGRAM_VOLTAGE_ENABLE];
    assign shadow_mapped = !cfg_reg[`EEP_CFG_SHADOW_HIDE];
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_array = aw_addr_reg[15:14] == `EEP_ARRAY_SEL_BITS;
    assign wr_ofs = aw_addr_reg[13:2];

    // ==================================================
    // axi handshakes: address and data taken in either order, one write at a time
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rd_pending_reg && !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 16'h0000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `EEP_RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            if (wr_array || aw_addr_reg == `EEP_ADDR_CONFIG || aw_addr_reg == `EEP_ADDR_PROTECT
                    || aw_addr_reg == `EEP_ADDR_DIV_HIGH || aw_addr_reg == `EEP_ADDR_DIV_LOW
                    || aw_addr_reg == `EEP_ADDR_CONTROL) begin
                bresp_reg <= `EEP_RESP_OKAY;
            end else begin
                bresp_reg <= `EEP_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ==================================================
    // reset load of the shadow word, taken one edge after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_pending_reg <= 1'b1;
        end else begin
            load_pending_reg <= 1'b0;
        end
    end

    // ==================================================
    // module configuration: upper bits writable only in special mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg <= {4'hF, `EEP_CFG_LOW_RESET};
        end else if (load_pending_reg) begin
            cfg_reg[7:4] <= shadow_high_in[7:4];
        end else if (do_write && aw_addr_reg == `EEP_ADDR_CONFIG && w_strb_reg[0]) begin
            if (!special_mode_n) begin
                cfg_reg[7:4] <= w_data_reg[7:4];
            end
            cfg_reg[2] <= w_data_reg[2];
            cfg_reg[0] <= w_data_reg[0];
            // protect lock is write once in normal mode, free in special mode
            if (!special_mode_n || !cfg_reg[`EEP_CFG_PROTECT_LOCK]) begin
                cfg_reg[`EEP_CFG_PROTECT_LOCK] <= w_data_reg[`EEP_CFG_PROTECT_LOCK];
            end
        end
    end

    assign debug_lockout_disable = cfg_reg[`EEP_CFG_DEBUG_LOCKOUT_DISABLE];

    // ==================================================
    // block protect, frozen while programming or when locked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prot_reg <= `EEP_PROT_RESET;
        end else if (do_write && aw_addr_reg == `EEP_ADDR_PROTECT && w_strb_reg[0] && !pgm
                && !cfg_reg[`EEP_CFG_PROTECT_LOCK]) begin
            prot_reg <= w_data_reg[7:0];
        end
    end

    // ==================================================
    // prescale divider: shadow load at reset, write once in normal mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_high_reg <= 2'h0;
            div_high_locked_reg <= 1'b0;
        end else if (load_pending_reg) begin
            div_high_reg <= shadow_high_in[1:0];
        end else if (do_write && aw_addr_reg == `EEP_ADDR_DIV_HIGH && w_strb_reg[0]) begin
            if (!special_mode_n || !div_high_locked_reg) begin
                div_high_reg <= w_data_reg[1:0];
            end
            div_high_locked_reg <= special_mode_n;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_low_reg <= 8'h00;
            div_low_locked_reg <= 1'b0;
        end else if (load_pending_reg) begin
            div_low_reg <= shadow_low_in;
        end else if (do_write && aw_addr_reg == `EEP_ADDR_DIV_LOW && w_strb_reg[0]) begin
            if (!special_mode_n || !div_low_locked_reg) begin
                div_low_reg <= w_data_reg[7:0];
            end
            div_low_locked_reg <= special_mode_n;
        end
    end

    // ==================================================
    // control register and cycle end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_reg <= `EEP_CTL_RESET;
        end else if (pgm) begin
            // only the voltage enable may change during a cycle
            if (cycle_done && ctl_reg[`EEP_CTL_AUTO]) begin
                ctl_reg[`EEP_CTL_PROGRAM_VOLTAGE_ENABLE] <= 1'b0;
            end else if (do_write && aw_addr_reg == `EEP_ADDR_CONTROL && w_strb_reg[0]) begin
                ctl_reg[`EEP_CTL_PROGRAM_VOLTAGE_ENABLE] <= w_data_reg[0];
            end
        end else if (do_write && aw_addr_reg == `EEP_ADDR_CONTROL && w_strb_reg[0]) begin
            ctl_reg[5:2] <= w_data_reg[5:2];
            if (!cfg_reg[`EEP_CFG_PROTECT_LOCK]) begin
                ctl_reg[`EEP_CTL_BULK_PROTECT] <= w_data_reg[7];
            end
            if (divider != 10'h000) begin
                ctl_reg[`EEP_CTL_LATCH_ENABLE] <= w_data_reg[1];
            end
            // a zero divider would overstress the array, so no start then
            ctl_reg[`EEP_CTL_PROGRAM_VOLTAGE_ENABLE] <= w_data_reg[0] && w_data_reg[1]
                && ctl_reg[`EEP_CTL_LATCH_ENABLE] && (divider != 10'h000);
        end
    end

    assign latch_enable = ctl_reg[`EEP_CTL_LATCH_ENABLE];
    assign program_voltage_enable = pgm;

    // ==================================================
    // cycle timing from the self-timed pulses
    eep_tick_gen u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(pgm),
        .divider(divider),
        .tick(tick)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn || !pgm) begin
            tick_count_reg <= 9'h000;
        end else if (tick && !cycle_done) begin
            tick_count_reg <= tick_count_reg + 9'h001;
        end
    end

    assign cycle_done = tick_count_reg == 9'(`EEP_PROGRAM_TICKS);

    // ==================================================
    // address and data latch for the array cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_addr_reg <= 12'h000;
            latch_data_reg <= 16'h0000;
            latch_word_reg <= 1'b0;
        end else if (do_write && wr_array && latch_enable && !pgm) begin
            latch_word_reg <= w_strb_reg[1];
            latch_data_reg <= w_strb_reg[1] ? w_data_reg[15:0] : {8'h00, w_data_reg[7:0]};
            latch_addr_reg <= w_strb_reg[1] ? {wr_ofs[11:1], 1'b0} : wr_ofs;
        end
    end

    assign prog_addr = latch_addr_reg;
    assign prog_data = latch_data_reg;
    assign prog_word = latch_word_reg;
    // protected shadow word gets no flag: the flag marks a mapped, unprotected shadow word target
    assign prog_shadow = shadow_mapped && {latch_addr_reg[11:1], 1'b0} == `EEP_SHADOW_HIGH_OFS
        && !prot_reg[`EEP_PROT_SHADOW_WRITE_PROTECT];

    always_comb begin
        if (!ctl_reg[`EEP_CTL_ERASE]) begin
            prog_op = eep_pkg::EEP_OP_PROGRAM;
        end else if (ctl_reg[`EEP_CTL_BYTE]) begin
            prog_op = eep_pkg::EEP_OP_ERASE_WORD;
        end else if (ctl_reg[`EEP_CTL_ROW]) begin
            prog_op = eep_pkg::EEP_OP_ERASE_ROW;
        end else begin
            prog_op = eep_pkg::EEP_OP_ERASE_BULK;
        end
    end

    // ==================================================
    // read path: address registered, answer one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_addr_reg <= 16'h0000;
            rd_pending_reg <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            ar_addr_reg <= s_axi_araddr;
            rd_pending_reg <= 1'b1;
        end else begin
            rd_pending_reg <= 1'b0;
        end
    end

    assign array_raddr = ar_addr_reg[13:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `EEP_RESP_OKAY;
        end else if (rd_pending_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= `EEP_RESP_OKAY;
            if (ar_addr_reg[15:14] == `EEP_ARRAY_SEL_BITS) begin
                if (shadow_mapped && array_raddr == `EEP_SHADOW_HIGH_OFS) begin
                    rdata_reg <= {24'h000000, shadow_high_in};
                end else if (shadow_mapped && array_raddr == `EEP_SHADOW_LOW_OFS) begin
                    rdata_reg <= {24'h000000, shadow_low_in};
                end else begin
                    rdata_reg <= {24'h000000, array_rdata};
                end
            end else if (ar_addr_reg == `EEP_ADDR_CONFIG) begin
                rdata_reg <= {24'h000000, cfg_reg[7:4], 1'b1, cfg_reg[2:0]};
            end else if (ar_addr_reg == `EEP_ADDR_PROTECT) begin
                rdata_reg <= {24'h000000, prot_reg};
            end else if (ar_addr_reg == `EEP_ADDR_DIV_HIGH) begin
                rdata_reg <= {30'h00000000, div_high_reg};
            end else if (ar_addr_reg == `EEP_ADDR_DIV_LOW) begin
                rdata_reg <= {24'h000000, div_low_reg};
            end else if (ar_addr_reg == `EEP_ADDR_CONTROL) begin
                rdata_reg <= {24'h000000, ctl_reg[7], 1'b0, ctl_reg[5:0]};
            end else begin
                rdata_reg <= 32'h00000000;
                rresp_reg <= `EEP_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

endmodule

// ==== dv/eep_array_model.sv ====
// behavioural model of the nonvolatile array read port
`timescale 1ns/1ps

module eep_array_model (
    // read port from the controller
    input wire logic [11:0] array_raddr,
    // byte at that offset
    output logic [7:0] array_rdata
);
    // =====================================
    // content
    // a pattern rather than a blank array, so a wrong offset or a leaked shadow byte shows
    assign array_rdata = array_raddr[7:0] ^ 8'hA5;
endmodule

// ==== dv/eep_ctrl_checker.sv ====
// concurrent checks on the ports of the program and erase controller
`timescale 1ns/1ps

module eep_ctrl_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus requests
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    // shadow contents
    input wire logic [7:0] shadow_high_in,
    // array side
    input wire logic [11:0] array_raddr,
    input wire logic latch_enable,
    input wire logic program_voltage_enable,
    input wire logic [11:0] prog_addr,
    input wire logic [15:0] prog_data,
    input wire logic prog_word,
    input wire logic prog_shadow,
    input wire logic debug_lockout_disable
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // =====================================
    // helpers
    wire logic [11:0] aw_offset = s_axi_awaddr[13:2];
    wire logic [11:0] ar_offset = s_axi_araddr[13:2];
    wire logic [7:0] w_byte = s_axi_wdata[7:0];

    sequence s_array_byte_write;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr[15:14] == 2'h1 && !s_axi_wstrb[1]
            && latch_enable && !program_voltage_enable;
    endsequence

    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    sequence s_voltage_held;
        program_voltage_enable ##1 program_voltage_enable;
    endsequence

    // =====================================
    // assertions
    AST_VOLTAGE_AFTER_LATCH: assert property (
        $rose(program_voltage_enable) |-> $past(latch_enable))
        else $error("voltage enable rose without latch enable set before");
    AST_LATCH_UNDER_VOLTAGE: assert property (program_voltage_enable |-> latch_enable)
        else $error("voltage enable high while latch enable low");
    AST_LATCH_KEPT: assert property (
        $fell(latch_enable) |-> !$past(program_voltage_enable))
        else $error("latch enable dropped while voltage was applied");
    AST_TARGET_FROZEN: assert property (s_voltage_held |->
        $stable(prog_addr) && $stable(prog_data) && $stable(prog_word))
        else $error("latched target changed while voltage applied");
    AST_TARGET_CAPTURE: assert property (s_array_byte_write |-> ##2
        prog_addr == $past(aw_offset, 2) && prog_data[7:0] == $past(w_byte, 2))
        else $error("array byte write not latched as target");
    AST_RESET_LOADS_CONFIG: assert property ($rose(aresetn) |=>
        debug_lockout_disable == shadow_high_in[7])
        else $error("lockout disable not loaded from shadow high bit 7");
    AST_SHADOW_SLOT_ONLY: assert property (prog_shadow |-> prog_addr[11:1] == 11'h7E0)
        else $error("shadow target flagged outside the two top slots");
    AST_READ_OFFSET: assert property (s_read_taken |=> array_raddr == $past(ar_offset))
        else $error("array read offset not taken from read address");
endmodule

// ==== dv/eep_program_erase_control_bench.sv ====
// self-checking bench for the program and erase controller
`timescale 1ns/1ps
`include "eep_consts.svh"

module eep_program_erase_control_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] awaddr = 16'h0000;
    logic [15:0] araddr = 16'h0000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic special_mode_n = 1'b1;
    logic [7:0] shadow_high_in = 8'hBE, shadow_low_in = 8'h05, array_rdata;
    logic awready, wready, bvalid, arready, rvalid, prog_word, prog_shadow;
    logic latch_enable, program_voltage_enable, debug_lockout_disable;
    logic [1:0] bresp, rresp, prog_op, resp;
    logic [31:0] rdata, rd;
    logic [11:0] array_raddr, prog_addr;
    logic [15:0] prog_data;
    int failures = 0, checks_done = 0, cycles = 0, pgm_cycles = 0, polls;

    // =====================================
    // clock, watchdog, voltage time
    initial begin
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (program_voltage_enable === 1'b1) pgm_cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    eep_program_erase_ctrl dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .special_mode_n(special_mode_n), .shadow_high_in(shadow_high_in),
        .shadow_low_in(shadow_low_in), .array_raddr(array_raddr), .array_rdata(array_rdata),
        .latch_enable(latch_enable), .program_voltage_enable(program_voltage_enable),
        .prog_addr(prog_addr), .prog_data(prog_data), .prog_word(prog_word),
        .prog_shadow(prog_shadow), .prog_op(prog_op),
        .debug_lockout_disable(debug_lockout_disable));

    eep_array_model array_model (.array_raddr(array_raddr), .array_rdata(array_rdata));

    // =====================================
    // bus and check tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic axi_write(input logic [15:0] a, input logic [31:0] d,
            input logic [3:0] s = 4'h1);
        logic aw_d, w_d, b_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        b_d = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_d) begin
            @(posedge aclk);
            if (!aw_d && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_d = 1'b1;
            end
            if (!w_d && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_d = 1'b1;
            end
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                b_d = 1'b1;
            end
        end
    endtask

    task automatic axi_read(input logic [15:0] a);
        logic ar_d, r_d;
        ar_d = 1'b0;
        r_d = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_d) begin
            @(posedge aclk);
            if (!ar_d && arready === 1'b1) begin
                arvalid <= 1'b0;
                ar_d = 1'b1;
            end
            if (rvalid === 1'b1) begin
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
                r_d = 1'b1;
            end
        end
    endtask

    task automatic rd_check(input string what, input logic [15:0] a, input logic [31:0] exp);
        axi_read(a);
        check(what, rd, exp);
    endtask

    // shadow inputs held steady across the release edge, where they are loaded
    task automatic do_reset(input logic sm_n, input logic [7:0] hi, input logic [7:0] lo);
        @(posedge aclk);
        aresetn <= 1'b0;
        special_mode_n <= sm_n;
        shadow_high_in <= hi;
        shadow_low_in <= lo;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    task report_and_stop;
        if (failures == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // =====================================
    // main sequence
    initial begin
        do_reset(1'b1, 8'hBE, 8'h05);
        check("lockout_out", debug_lockout_disable, 32'h1);
        rd_check("config", `EEP_ADDR_CONFIG, 32'hBC);
        rd_check("div_high", `EEP_ADDR_DIV_HIGH, 32'h02);
        rd_check("div_low", `EEP_ADDR_DIV_LOW, 32'h05);
        // divider 1 keeps the timed cycle short
        axi_write(`EEP_ADDR_DIV_HIGH, 32'h00);
        axi_write(`EEP_ADDR_DIV_LOW, 32'h01);
        axi_write(`EEP_ADDR_DIV_LOW, 32'h07);
        rd_check("div_low_once", `EEP_ADDR_DIV_LOW, 32'h01);
        rd_check("shadow_high", 16'h7F00, 32'hBE);
        rd_check("shadow_low", 16'h7F04, 32'h05);
        rd_check("array_plain", 16'h4040, 32'h10 ^ 32'hA5);
        axi_write(`EEP_ADDR_CONTROL, 32'h03);
        rd_check("latch_only", `EEP_ADDR_CONTROL, 32'h02);
        axi_write(16'h4040, 32'h5A);
        check("target_addr", prog_addr, 32'h010);
        axi_write(`EEP_ADDR_CONTROL, 32'h03);
        check("voltage_on", program_voltage_enable, 32'h1);
        axi_write(16'h4044, 32'h77);
        check("held_data", prog_data[7:0], 32'h5A);
        check("held_addr", prog_addr, 32'h010);
        axi_write(`EEP_ADDR_CONTROL, 32'h02);
        rd_check("voltage_off", `EEP_ADDR_CONTROL, 32'h02);
        axi_write(16'h404C, 32'h1234, 4'h3);
        check("word_addr", prog_addr, 32'h012);
        check("word_data", prog_data, 32'h1234);
        check("word_flag", prog_word, 32'h1);
        axi_write(`EEP_ADDR_CONTROL, 32'h22);
        pgm_cycles = 0;
        axi_write(`EEP_ADDR_CONTROL, 32'h23);
        polls = 0;
        do begin
            axi_read(`EEP_ADDR_CONTROL);
            polls++;
        end while (rd[0] !== 1'b0 && polls < 200);
        check("auto_cleared", rd[0], 32'h0);
        check("auto_time", 32'(pgm_cycles >= `EEP_PROGRAM_TICKS
            && pgm_cycles <= `EEP_PROGRAM_TICKS + 4), 32'h1);
        check("latch_kept", latch_enable, 32'h1);
        axi_write(`EEP_ADDR_CONTROL, 32'h00);
        check("latch_off", latch_enable, 32'h0);
        // unmapped place answers with a slave error
        axi_read(16'h0100);
        check("bad_read_resp", resp, 32'h2);
        axi_write(16'h0100, 32'h11);
        check("bad_write_resp", resp, 32'h2);
        // zero divider and hidden shadow word
        do_reset(1'b1, 8'hFC, 8'h00);
        axi_write(`EEP_ADDR_CONTROL, 32'h02);
        check("no_latch_zero_div", latch_enable, 32'h0);
        rd_check("shadow_hidden", 16'h7F00, 32'hC0 ^ 32'hA5);
        // special mode never locks the divider
        do_reset(1'b0, 8'hBE, 8'h01);
        axi_write(`EEP_ADDR_DIV_LOW, 32'h03);
        axi_write(`EEP_ADDR_DIV_LOW, 32'h04);
        rd_check("div_special", `EEP_ADDR_DIV_LOW, 32'h04);
        axi_write(`EEP_ADDR_PROTECT, 32'h7F);
        axi_write(`EEP_ADDR_CONFIG, 32'hB0);
        axi_write(`EEP_ADDR_CONTROL, 32'h16);
        check("op_erase_word", prog_op, 32'h1);
        axi_write(16'h7F04, 32'h04);
        check("shadow_target", prog_shadow, 32'h1);
        axi_write(`EEP_ADDR_PROTECT, 32'hFF);
        check("shadow_guarded", prog_shadow, 32'h0);
        report_and_stop();
    end
endmodule

bind eep_program_erase_ctrl eep_ctrl_checker chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .shadow_high_in(shadow_high_in), .array_raddr(array_raddr), .latch_enable(latch_enable),
    .program_voltage_enable(program_voltage_enable), .prog_addr(prog_addr),
    .prog_data(prog_data), .prog_word(prog_word), .prog_shadow(prog_shadow),
    .debug_lockout_disable(debug_lockout_disable));
